// file: hw/gpio_remap_port.sv
// Overview of operation
// - Active peripheral disables port driver, pin readable
// - Idle enabled peripheral lets port drive
// - Mux pair picks peripheral or port
// - Port output never loops into peripherals
// - Direction one means input
// - All pins inputs after reset
// - Latch reads latch, writes latch
// - Level reads pins, writes latch
// - Absent bits read zero everywhere
// - Input-only sharing leaves port sole driver
// - Pins 10/11 selects absent on small variant
// - Unused select bits read zero
//
// Top level: GPIO port registers, pin ownership and pin remap.
// Assumes an APB master on sys_clk_i and pins synchronous to it.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module gpio_remap_port
   import gpio_remap_pkg::*;
#(
   parameter int unsigned          PORT_W   = 26,
   parameter int unsigned          FUNC_N   = 32,
   parameter logic [PORT_W-1:0]    IMPL     = '1,
   parameter bit                   HAS_PIN_AB = 1'b1
)(
   input  wire logic                sys_clk_i,
   input  wire logic                reset_n_i,
   input  wire logic                clk_en_i,
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [7:0]          paddr_i,
   input  wire logic [31:0]         pwdata_i,
   output logic [31:0]              prdata_o,
   output logic                     pready_o,
   output logic                     pslverr_o,
   input  wire logic [PORT_W-1:0]   pin_in_i,
   output logic [PORT_W-1:0]        pin_out_o,
   output logic [PORT_W-1:0]        pin_oe_o,
   input  wire logic [PORT_W-1:0]   periph_enable_i,
   input  wire logic [PORT_W-1:0]   periph_oe_i,
   input  wire logic [PORT_W-1:0]   periph_data_i,
   input  wire logic [FUNC_N-1:0]   func_data_i,
   input  wire logic [FUNC_N-1:0]   func_oe_i,
   output logic [PORT_W-1:0]        periph_in_o,
   output logic                     spi_clock_input_o,
   output logic                     spi_data_input_o
);
   import gpio_remap_pkg::*;

   // Port state
   logic [PORT_W-1:0] pin_direction_reg;   // One means input
   logic [PORT_W-1:0] output_latch_reg;    // Written latch value
   logic [PORT_W-1:0] pin_level_reg;       // Sampled pin states

   // Select fields
   logic [4:0] spi_clock_in_select;
   logic [4:0] spi_data_in_select;
   logic [4:0] remap_pin8_out_select;
   logic [4:0] remap_pin9_out_select;
   logic [4:0] remap_pin10_out_select;
   logic [4:0] remap_pin11_out_select;

   // Bus phases
   logic setup_w;     // First cycle of a transfer
   logic wr_w;        // Write takes effect this edge
   logic [31:0] rd_next;
   logic        err_next;

   // Ownership view
   pin_drive_t periph_w [PORT_W];
   pin_drive_t pin_w    [PORT_W];
   logic [PORT_W-1:0] port_drv_w;
   logic [PORT_W-1:0] remap_own_w;

   // Frozen clock enable stalls the bus too
   assign pready_o = clk_en_i;
   assign setup_w  = psel_i & ~penable_i;
   assign wr_w     = psel_i & penable_i & pwrite_i & clk_en_i;

   // Two five-bit fields packed into one word
   function automatic logic [31:0] pack_sel(input logic [4:0] hi, input logic [4:0] lo);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[HI_LSB +: SEL_W] = hi;
      v[LO_LSB +: SEL_W] = lo;
      return v;
   endfunction

   // Peripheral function driving a remapped pin
   function automatic pin_drive_t func_pick(input logic [4:0] sel);
      pin_drive_t d;
      d.data = 1'b0;
      d.oe   = 1'b0;
      if (sel != OUT_SEL_NONE && 32'(sel) < FUNC_N)
      begin
         d.data = func_data_i[sel];
         d.oe   = func_oe_i[sel];
      end
      return d;
   endfunction

   // Ownership flag alone; avoids selecting a member of a call result
   function automatic logic func_owns(input logic [4:0] sel);
      pin_drive_t d;
      d = func_pick(sel);
      return d.oe;
   endfunction

   // Direction register
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         pin_direction_reg <= '1;
      else if (wr_w && paddr_i == DIR_OFS)
         pin_direction_reg <= pwdata_i[PORT_W-1:0];
   end

   // Latch written through either latch or level address
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         output_latch_reg <= '0;
      else if (wr_w && (paddr_i == LAT_OFS || paddr_i == LEVEL_OFS))
         output_latch_reg <= pwdata_i[PORT_W-1:0];
   end

   // Pin sampling, absent pins held at zero
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         pin_level_reg <= '0;
      else if (clk_en_i)
         pin_level_reg <= pin_in_i & IMPL;
   end

   // Input select fields
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         spi_clock_in_select <= IN_SEL_RST;
         spi_data_in_select  <= IN_SEL_RST;
      end
      else if (wr_w && paddr_i == SPI_SEL_OFS)
      begin
         spi_clock_in_select <= pwdata_i[HI_LSB +: SEL_W];
         spi_data_in_select  <= pwdata_i[LO_LSB +: SEL_W];
      end
   end

   // Output select fields for pins 8 and 9
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         remap_pin9_out_select <= OUT_SEL_RST;
         remap_pin8_out_select <= OUT_SEL_RST;
      end
      else if (wr_w && paddr_i == OSEL_89_OFS)
      begin
         remap_pin9_out_select <= pwdata_i[HI_LSB +: SEL_W];
         remap_pin8_out_select <= pwdata_i[LO_LSB +: SEL_W];
      end
   end

   // Pins 10 and 11 fields; writes dropped on the small variant
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         remap_pin11_out_select <= OUT_SEL_RST;
         remap_pin10_out_select <= OUT_SEL_RST;
      end
      else if (wr_w && paddr_i == OSEL_AB_OFS && HAS_PIN_AB)
      begin
         remap_pin11_out_select <= pwdata_i[HI_LSB +: SEL_W];
         remap_pin10_out_select <= pwdata_i[LO_LSB +: SEL_W];
      end
   end

   // Read data chosen in setup, absent bits masked
   always_comb
   begin
      rd_next  = 32'h0000_0000;
      err_next = 1'b0;
      unique case (paddr_i)
         DIR_OFS:     rd_next = 32'(pin_direction_reg & IMPL);
         LAT_OFS:     rd_next = 32'(output_latch_reg & IMPL);
         LEVEL_OFS:   rd_next = 32'(pin_level_reg);
         SPI_SEL_OFS: rd_next = pack_sel(spi_clock_in_select, spi_data_in_select);
         OSEL_89_OFS: rd_next = pack_sel(remap_pin9_out_select, remap_pin8_out_select);
         OSEL_AB_OFS: rd_next = pack_sel(remap_pin11_out_select, remap_pin10_out_select);
         // Unmapped address reads zero with an error
         default:     err_next = 1'b1;
      endcase
   end

   // Answer registered at setup, stands through access
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end
      else if (clk_en_i && setup_w)
      begin
         prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_next;
         pslverr_o <= err_next;
      end
   end

   // Peripheral drive requests per pin
   always_comb
   begin
      for (int i = 0; i < PORT_W; i++)
      begin
         // Enabled and driving peripheral claims the pin
         periph_w[i].data = periph_data_i[i];
         periph_w[i].oe   = periph_enable_i[i] & periph_oe_i[i] & IMPL[i];
      end
      // Remapped functions override the fixed peripheral
      if (PORT_W > OSEL_PIN11)
      begin
         if (remap_own_w[OSEL_PIN8])
            periph_w[OSEL_PIN8] = func_pick(remap_pin8_out_select);
         if (remap_own_w[OSEL_PIN9])
            periph_w[OSEL_PIN9] = func_pick(remap_pin9_out_select);
         if (remap_own_w[OSEL_PIN10])
            periph_w[OSEL_PIN10] = func_pick(remap_pin10_out_select);
         if (remap_own_w[OSEL_PIN11])
            periph_w[OSEL_PIN11] = func_pick(remap_pin11_out_select);
      end
   end

   // Pins whose output select names a function that is driving its output enable
   always_comb
   begin
      remap_own_w = '0;
      if (PORT_W > OSEL_PIN11)
      begin
         remap_own_w[OSEL_PIN8]  = func_owns(remap_pin8_out_select);
         remap_own_w[OSEL_PIN9]  = func_owns(remap_pin9_out_select);
         remap_own_w[OSEL_PIN10] = func_owns(remap_pin10_out_select);
         remap_own_w[OSEL_PIN11] = func_owns(remap_pin11_out_select);
      end
   end

   // Ownership multiplexers
   pin_owner_mux #(
      .W           (PORT_W)
   ) owner_mux (
      .dir_i       (pin_direction_reg),
      .lat_i       (output_latch_reg),
      .impl_i      (IMPL),
      .periph_i    (periph_w),
      .pin_level_i (pin_level_reg),
      .pin_o       (pin_w),
      .port_drv_o  (port_drv_w),
      .periph_in_o (periph_in_o)
   );

   // Flatten pin drivers onto ports
   always_comb
   begin
      for (int i = 0; i < PORT_W; i++)
      begin
         pin_out_o[i] = pin_w[i].data;
         pin_oe_o[i]  = pin_w[i].oe;
      end
   end

   // Input-only functions only listen; port stays the driver
   remap_input_select #(
      .W      (PORT_W)
   ) clock_select (
      .sel_i  (spi_clock_in_select),
      .pins_i (periph_in_o),
      .in_o   (spi_clock_input_o)
   );

   remap_input_select #(
      .W      (PORT_W)
   ) data_select (
      .sel_i  (spi_data_in_select),
      .pins_i (periph_in_o),
      .in_o   (spi_data_input_o)
   );

   // Checks on pin ownership and register behaviour
   default clocking chk_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   periph_owns_a : assert property (
      ((pin_out_o ^ periph_data_i) & periph_enable_i & periph_oe_i & IMPL & ~remap_own_w) == '0)
      else $error("Driving peripheral does not own pin data");

   port_drives_a : assert property (
      ((pin_oe_o ^ ~pin_direction_reg) & ~(periph_enable_i & periph_oe_i) & ~remap_own_w & IMPL) == '0)
      else $error("Idle peripheral blocks port driver");

   no_loop_a : assert property (
      (periph_in_o & IMPL & ~pin_direction_reg & ~(periph_enable_i & periph_oe_i) & ~remap_own_w) == '0)
      else $error("Port output loops into peripheral input");

   input_dir_a : assert property (
      (wr_w && paddr_i == DIR_OFS && pwdata_i[0] && !periph_oe_i[0]) |=> !pin_oe_o[0])
      else $error("Input direction still drives pin");

   latch_read_a : assert property (
      (clk_en_i && setup_w && !pwrite_i && paddr_i == LAT_OFS) |=> prdata_o == 32'(output_latch_reg & IMPL))
      else $error("Latch read returns wrong value");

   level_write_a : assert property (
      (wr_w && paddr_i == LEVEL_OFS) |=> output_latch_reg == $past(pwdata_i[PORT_W-1:0]))
      else $error("Level write missed the latch");

   absent_zero_a : assert property (
      (clk_en_i && setup_w && !pwrite_i && (paddr_i == DIR_OFS || paddr_i == LAT_OFS))
      |=> (prdata_o & ~32'(IMPL)) == 32'h0000_0000)
      else $error("Absent port bit reads nonzero");

   sel_gap_a : assert property (
      (clk_en_i && setup_w && (paddr_i == SPI_SEL_OFS || paddr_i == OSEL_89_OFS))
      |=> prdata_o[31:13] == '0 && prdata_o[7:5] == 3'h0)
      else $error("Unused select bits read nonzero");

   ground_sel_a : assert property (
      !sel_is_pin(spi_clock_in_select) |-> !spi_clock_input_o ##1 1'b1)
      else $error("Reserved input code not held low");

   // Main scenarios
   periph_take_c : cover property (periph_enable_i[0] && periph_oe_i[0] && !pin_direction_reg[0]);
   remap_out_c   : cover property (remap_own_w[OSEL_PIN8] ##1 !remap_own_w[OSEL_PIN8]);
   spi_route_c   : cover property (sel_is_pin(spi_data_in_select) && spi_data_input_o);
   err_resp_c    : cover property (psel_i && penable_i && pslverr_o);

endmodule

// file: hw/gpio_remap_pkg.sv
// Shared constants and types for the GPIO port with remappable pins.
// Assumes an APB master with 32-bit data and byte addresses.
package gpio_remap_pkg;

   // Register byte offsets
   localparam logic [7:0] DIR_OFS      = 8'h00;
   localparam logic [7:0] LAT_OFS      = 8'h04;
   localparam logic [7:0] LEVEL_OFS    = 8'h08;
   localparam logic [7:0] SPI_SEL_OFS  = 8'h0C;
   localparam logic [7:0] OSEL_89_OFS  = 8'h10;
   localparam logic [7:0] OSEL_AB_OFS  = 8'h14;

   // Select field layout
   localparam int unsigned SEL_W      = 5;
   localparam int unsigned HI_LSB     = 8;
   localparam int unsigned LO_LSB     = 0;

   // Select encodings and reset values
   localparam logic [4:0] SEL_GROUND   = 5'h1F;
   localparam logic [4:0] SEL_LAST_PIN = 5'h19;
   localparam logic [4:0] IN_SEL_RST   = 5'h1F;
   localparam logic [4:0] OUT_SEL_RST  = 5'h00;
   localparam logic [4:0] OUT_SEL_NONE = 5'h00;

   // Pins that own an output-select field
   localparam int unsigned OSEL_PIN8  = 8;
   localparam int unsigned OSEL_PIN9  = 9;
   localparam int unsigned OSEL_PIN10 = 10;
   localparam int unsigned OSEL_PIN11 = 11;

   // Data and enable of one pin driver
   typedef struct packed {
      logic data;
      logic oe;
   } pin_drive_t;

   // Input code names a real remappable pin
   function automatic logic sel_is_pin(input logic [4:0] sel);
      return (sel <= SEL_LAST_PIN);
   endfunction

endpackage

// file: hw/pin_owner_mux.sv
// Per-pin ownership multiplexer between peripheral and port.
// Assumes peripheral drive requests are already qualified by enable.
`timescale 1ns/1ps
module pin_owner_mux
   import gpio_remap_pkg::*;
#(
   parameter int unsigned W = 26
)(
   input  wire logic [W-1:0] dir_i,
   input  wire logic [W-1:0] lat_i,
   input  wire logic [W-1:0] impl_i,
   input  wire pin_drive_t   periph_i [W],
   input  wire logic [W-1:0] pin_level_i,
   output pin_drive_t        pin_o    [W],
   output logic [W-1:0]      port_drv_o,
   output logic [W-1:0]      periph_in_o
);
   // One mux pair per pin
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         // Port drives only an output bit that exists, not owned
         port_drv_o[i] = impl_i[i] & ~dir_i[i] & ~periph_i[i].oe;
         // Peripheral wins data and enable while driving
         pin_o[i].data = periph_i[i].oe ? periph_i[i].data : lat_i[i];
         pin_o[i].oe   = periph_i[i].oe | port_drv_o[i];
         // Own port output never reaches a peripheral input
         periph_in_o[i] = pin_level_i[i] & ~port_drv_o[i];
      end
   end
endmodule

// file: hw/remap_input_select.sv
// Routes one remappable pin onto one peripheral input.
// Assumes pin views are already free of port loop-through.
`timescale 1ns/1ps
module remap_input_select
   import gpio_remap_pkg::*;
#(
   parameter int unsigned W = 26
)(
   input  wire logic [4:0]   sel_i,
   input  wire logic [W-1:0] pins_i,
   output logic              in_o
);
   // Ground, reserved and absent pins all give a low input
   always_comb
   begin
      in_o = 1'b0;
      if (sel_is_pin(sel_i) && (32'(sel_i) < W))
      begin
         in_o = pins_i[sel_i];
      end
   end
endmodule

// file: sim/pin_partner.sv
// Pad model: resolves each pin from the port drive and an outside source.
// Assumes the outside source is weak and yields wherever the port drives.
`timescale 1ns/1ps
module pin_partner
#(
   parameter int unsigned W = 26
)(
   input  wire logic [W-1:0] pin_out_i,
   input  wire logic [W-1:0] pin_oe_i,
   input  wire logic [W-1:0] ext_i,
   output logic [W-1:0]      pin_in_o
);
   // Driven pins follow the port, released pins the outside level
   always_comb
   begin
      pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
   end
endmodule

// file: sim/gpio_port_with_pin_remap_tb.sv
// Self-checking bench for the GPIO port with remappable pins.
// Assumes the design's default parameters: 26 pins, all implemented.
`timescale 1ns/1ps
module gpio_port_with_pin_remap_tb;
   import gpio_remap_pkg::*;
   localparam logic [31:0] RST_VAL [6] = '{32'h03FF_FFFF, 32'h0, 32'h0, 32'h1F1F, 32'h0, 32'h0};
   localparam logic [4:0]  CORNER  [6] = '{5'h1F, 5'h1A, 5'h1E, 5'h00, 5'h19, 5'h0C};
   logic        sys_clk, reset_n, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, fd, foe;
   logic [25:0] pin_in, pin_out, pin_oe, pe, poe, pd, ext, periph_in;
   logic        spi_clk, spi_dat;
   int          mismatches, n_compared;

   gpio_remap_port dut (
      .sys_clk_i(sys_clk), .reset_n_i(reset_n), .clk_en_i(clk_en), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pin_in_i(pin_in),
      .pin_out_o(pin_out), .pin_oe_o(pin_oe), .periph_enable_i(pe), .periph_oe_i(poe),
      .periph_data_i(pd), .func_data_i(fd), .func_oe_i(foe), .periph_in_o(periph_in),
      .spi_clock_input_o(spi_clk), .spi_data_input_o(spi_dat));

   // Outside world of the pins
   pin_partner pads (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_i(ext), .pin_in_o(pin_in));

   // 100 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Verdict and end of run
   task automatic complete_run();
      if (mismatches == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // One comparison, reported at once on mismatch
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer plus an idle cycle; entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hang
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1);
      // No wait states while the clock enable is high
      chk("pready wait", 32'(n), 32'h1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Read every register and compare with its reset value
   task automatic check_reset();
      logic [31:0] rd;
      logic        er;
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0, rd, er);
         chk("reset value", rd, RST_VAL[i]);
      end
   endtask

   // Expected pin drive: remap beats fixed peripheral, which beats the port
   function automatic void exp_pins(input logic [25:0] dir, lat, input logic [31:0] o89, oab,
                                    output logic [25:0] o, oe, drv);
      logic [25:0] own;
      logic [4:0]  f;
      own = pe & poe;
      oe  = own | ~dir;
      o   = (own & pd) | (~own & lat);
      drv = ~own & ~dir;
      for (int p = 8; p < 12; p++)
      begin
         f = (p < 10) ? (p[0] ? o89[12:8] : o89[4:0]) : (p[0] ? oab[12:8] : oab[4:0]);
         if (f != OUT_SEL_NONE && foe[f])
         begin
            oe[p]  = 1'b1;
            o[p]   = fd[f];
            drv[p] = 1'b0;
         end
      end
   endfunction

   // Watchdog: far beyond the expected run of about fourteen hundred cycles
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      complete_run();
   end

   // Main sequence
   initial
   begin
      logic [31:0] rd, sel_v, o89, oab;
      logic        er;
      logic [25:0] dir_v, lat_v, eo, eoe, drv, lvl, pin_ex;
      mismatches = 0;
      n_compared = 0;
      {reset_n, clk_en, psel, penable, pwrite, paddr, pwdata} = '0;
      {pe, poe, pd, ext, fd, foe} = '0;
      void'($urandom(32'hF74E2D9E));
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      clk_en  <= 1'b1;
      @(posedge sys_clk);
      check_reset();
      // Unmapped address is refused
      apb(1'b0, 8'h18, 32'h0, rd, er);
      chk("unmapped err", 32'(er), 32'h1);
      chk("unmapped data", rd, 32'h0);
      for (int k = 0; k < 40; k++)
      begin
         ext   <= 26'($urandom);
         pe    <= 26'($urandom);
         poe   <= 26'($urandom);
         pd    <= 26'($urandom);
         fd    <= $urandom;
         foe   <= $urandom;
         dir_v = 26'($urandom);
         lat_v = 26'($urandom);
         sel_v = $urandom;
         o89   = $urandom;
         oab   = $urandom;
         // Corner codes: ground, reserved edges, first and last pin, and pin 12
         if (k < 6)
         begin
            sel_v[12:8] = CORNER[k];
            sel_v[4:0]  = CORNER[5 - k];
         end
         // Output selects all zero leave pins 8 to 11 unremapped
         if (k == 0)
         begin
            o89 = 32'h0;
            oab = 32'h0;
         end
         apb(1'b1, DIR_OFS, {6'($urandom), dir_v}, rd, er);
         apb(1'b1, k[0] ? LEVEL_OFS : LAT_OFS, 32'(lat_v), rd, er);
         apb(1'b1, SPI_SEL_OFS, sel_v, rd, er);
         apb(1'b1, OSEL_89_OFS, o89, rd, er);
         apb(1'b1, OSEL_AB_OFS, oab, rd, er);
         exp_pins(dir_v, lat_v, o89, oab, eo, eoe, drv);
         pin_ex = (eoe & eo) | (~eoe & ext);
         lvl    = pin_ex & ~drv;
         apb(1'b0, LAT_OFS, 32'h0, rd, er);
         chk("latch", rd, 32'(lat_v));
         apb(1'b0, DIR_OFS, 32'h0, rd, er);
         chk("direction", rd, {6'h0, dir_v});
         apb(1'b0, SPI_SEL_OFS, 32'h0, rd, er);
         chk("input select", rd, sel_v & 32'h1F1F);
         apb(1'b0, OSEL_89_OFS, 32'h0, rd, er);
         chk("out select 8 9", rd, o89 & 32'h1F1F);
         apb(1'b0, OSEL_AB_OFS, 32'h0, rd, er);
         chk("out select 10 11", rd, oab & 32'h1F1F);
         apb(1'b0, LEVEL_OFS, 32'h0, rd, er);
         chk("pin level", rd, 32'(pin_ex));
         // Pins checked away from the clock edge
         @(negedge sys_clk);
         chk("pin enable", 32'(pin_oe), 32'(eoe));
         chk("pin data", 32'(pin_out & eoe), 32'(eo & eoe));
         chk("peripheral in", 32'(periph_in), 32'(lvl));
         chk("spi clock", 32'(spi_clk), (sel_v[12:8] <= SEL_LAST_PIN) ? 32'(lvl[sel_v[12:8]]) : 32'h0);
         chk("spi data", 32'(spi_dat), (sel_v[4:0] <= SEL_LAST_PIN) ? 32'(lvl[sel_v[4:0]]) : 32'h0);
         @(posedge sys_clk);
      end
      // Clock enable low holds the bus answer back
      clk_en <= 1'b0;
      ext    <= ~ext;
      @(negedge sys_clk);
      chk("pready frozen", 32'(pready), 32'h0);
      // Level register holds its old sample while frozen
      @(negedge sys_clk);
      chk("level frozen", 32'(periph_in), 32'(lvl));
      @(posedge sys_clk);
      clk_en <= 1'b1;
      pe     <= '0;
      ext    <= '0;
      // Second reset in mid-run restores every register
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("enables in reset", 32'(pin_oe), 32'h0);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      check_reset();
      complete_run();
   end
endmodule
